// [verilog/wct_pkg.sv]
// Constants, field layouts and encodings for the wave condition and trap logic.
// Assumes one core clock and a sequencer that presents one instruction event per cycle.
// Summary of operation
// - Vector compare writes mask bit as execute bit AND test pass.
// - Compare may also copy its new mask into the execute mask.
// - Summary flag is one when mask is zero, refreshed on every update.
// - Selected integer add and subtract write per-thread carry-out into the mask.
// - 32-bit encoding targets the mask; 64-bit encoding targets a named scalar pair.
// - Mask updates always replace the whole mask.
// - Scalar write by alias name inserts one wait before a summary-flag branch.
// - Trap base, memory and scratch writes take effect only when privileged.
// - Trap entry loads scratch pair with zeros, rewind, host flag, code, counter.
// - Host flag set only for host traps; code zero for exceptions.
// - Faulting address equals captured counter minus four times rewind count.
// - Without trap handler no trap is taken; trap instruction becomes no-op.
// - Nine exception enables, bit order invalid through memory violation.
// - Exception status bits are sticky, accumulate regardless of enables, unprivileged.
// - Status bit ten forces a context-save trap within two further instructions.
// - Bits 21:16 record phase, slot pass and hybrid pass of first enabled exception, invalid through integer divide only.
// - Listed local, memory, flat, read-only, global and semaphore errors raise violation.
// - Fetch and scalar data never violate; buffer-to-local clears affected execute bits.
// - Violation response sets sticky memory-violation status bit.
// - Enabled memory violation makes the wave branch to its handler.
// - Memory-violation traps save the next instruction's counter.
// - Exception traps need both their enable bit and the trap-present bit.
package wct_pkg;
  localparam int WCT_LANES = 64;
  localparam int WCT_PC_W = 48;
  localparam int WCT_EXC_N = 9;
  localparam int WCT_CYC_W = 6;
  localparam int WCT_MV_N = 8;
  // Exception bit positions.
  localparam int WCT_EX_INVALID = 0;
  localparam int WCT_EX_DENORM = 1;
  localparam int WCT_EX_DIV0 = 2;
  localparam int WCT_EX_OVFL = 3;
  localparam int WCT_EX_UNFL = 4;
  localparam int WCT_EX_INEXACT = 5;
  localparam int WCT_EX_INTDIV = 6;
  localparam int WCT_EX_WATCH = 7;
  localparam int WCT_EX_MEMVIOL = 8;
  // Status register layout.
  localparam int WCT_ST_EXC_LO = 0;
  localparam int WCT_ST_SAVE = 10;
  localparam int WCT_ST_CYC_LO = 16;
  localparam int WCT_ST_CYC_HI = 21;
  localparam logic [31:0] WCT_ST_RESET = 32'h0000_0000;
  localparam logic [31:0] WCT_ST_WMASK = 32'h003F_05FF;
  // Trap information layout.
  localparam logic [2:0] WCT_TI_PAD = 3'h0;
  localparam logic [7:0] WCT_CODE_EXC = 8'h00;
  localparam int WCT_REWIND_W = 4;
  localparam logic [WCT_REWIND_W-1:0] WCT_REWIND_ZERO = 4'h0;
  localparam int WCT_INSTR_BYTES = 4;
  localparam int WCT_SAVE_SLACK = 2;
  localparam logic [1:0] WCT_SAVE_SLACK_W = 2'h2;
  // Trap causes.
  typedef enum logic [3:0] {
    WCT_TRAP_NONE = 4'b0001,
    WCT_TRAP_USER = 4'b0010,
    WCT_TRAP_HOST = 4'b0100,
    WCT_TRAP_EXC = 4'b1000
  } wct_cause_t;
  // Mask update sources.
  typedef enum logic [2:0] {
    WCT_SRC_CMP = 3'b001,
    WCT_SRC_CARRY = 3'b010,
    WCT_SRC_SCALAR = 3'b100
  } wct_src_t;
endpackage : wct_pkg

// [verilog/wct_sticky.sv]
// One sticky flag whose hardware set wins over a software clear.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module wct_sticky (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic set_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic wval_i,
  output logic q_o
);
  wire next_q = set_i | (wr_i ? wval_i : (q_o & ~clr_i));
  // Set has priority so an event in the clearing cycle survives.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0;
    end else begin
      q_o <= next_q;
    end
  end
endmodule : wct_sticky

// [verilog/wct_core.sv]
// Condition mask, summary flag, trap status and trap entry capture for one wave.
// Assumes the sequencer drives one-cycle event strobes and honours trap_take_o.
`timescale 1ns/1ps
module wct_core (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic trap_present_i,
  input wire logic priv_i,
  input wire logic [wct_pkg::WCT_EXC_N-1:0] exc_enable_i,
  input wire logic cmp_valid_i,
  input wire logic cmp_wide_i,
  input wire logic cmp_to_exec_i,
  input wire logic [wct_pkg::WCT_LANES-1:0] cmp_pass_i,
  input wire logic carry_valid_i,
  input wire logic [wct_pkg::WCT_LANES-1:0] carry_out_i,
  input wire logic scalar_wr_i,
  input wire logic scalar_alias_i,
  input wire logic [wct_pkg::WCT_LANES-1:0] scalar_data_i,
  input wire logic exec_wr_i,
  input wire logic [wct_pkg::WCT_LANES-1:0] exec_data_i,
  input wire logic branch_summary_i,
  input wire logic instr_issue_i,
  input wire logic [wct_pkg::WCT_PC_W-1:0] next_pc_i,
  input wire logic [wct_pkg::WCT_REWIND_W-1:0] rewind_i,
  input wire logic [wct_pkg::WCT_EXC_N-2:0] exc_event_i,
  input wire logic [wct_pkg::WCT_CYC_W-1:0] exc_cycle_i,
  input wire logic [wct_pkg::WCT_MV_N-1:0] mem_viol_i,
  input wire logic fetch_or_scalar_i,
  input wire logic buf_lds_oor_i,
  input wire logic [wct_pkg::WCT_LANES-1:0] buf_lds_lanes_i,
  input wire logic user_trap_i,
  input wire logic [7:0] user_code_i,
  input wire logic host_trap_i,
  input wire logic [7:0] host_code_i,
  input wire logic host_save_i,
  input wire logic sts_wr_i,
  input wire logic [31:0] sts_wdata_i,
  input wire logic tpriv_wr_i,
  input wire logic [1:0] tpriv_sel_i,
  input wire logic [63:0] tpriv_wdata_i,
  output logic [wct_pkg::WCT_LANES-1:0] cond_mask_o,
  output logic [wct_pkg::WCT_LANES-1:0] exec_mask_o,
  output logic cond_zero_o,
  output logic cmp_sgpr_wr_o,
  output logic [wct_pkg::WCT_LANES-1:0] cmp_sgpr_data_o,
  output logic branch_stall_o,
  output logic [31:0] trap_status_o,
  output logic [63:0] trap_info_o,
  output logic [63:0] trap_base_o,
  output logic [63:0] trap_mem_o,
  output logic trap_take_o,
  output logic [wct_pkg::WCT_PC_W-1:0] fault_pc_o
);
  import wct_pkg::*;

  // Compare result and mask update selection.
  wire [WCT_LANES-1:0] cmp_res = exec_mask_o & cmp_pass_i;
  wire cmp_to_mask = cmp_valid_i & ~cmp_wide_i;
  wire mask_upd = cmp_to_mask | carry_valid_i | scalar_wr_i;
  // Whole-word replacement only; no bit-enable path exists into the mask.
  wire [WCT_LANES-1:0] next_cond_mask = cmp_to_mask ? cmp_res :
    carry_valid_i ? carry_out_i : scalar_data_i;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cond_mask_o <= '0;
      cond_zero_o <= 1'b1;
    end else if (mask_upd) begin
      cond_mask_o <= next_cond_mask;
      cond_zero_o <= (next_cond_mask == '0);
    end
  end

  // Wide compares go to the scalar pair named by the instruction.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmp_sgpr_wr_o <= 1'b0;
      cmp_sgpr_data_o <= '0;
    end else begin
      cmp_sgpr_wr_o <= cmp_valid_i & cmp_wide_i;
      cmp_sgpr_data_o <= cmp_res;
    end
  end

  // Execute mask: compare copy and buffer-to-local lane masking.
  wire [WCT_LANES-1:0] exec_base = exec_wr_i ? exec_data_i : exec_mask_o;
  wire [WCT_LANES-1:0] exec_cmp = (cmp_valid_i & cmp_to_exec_i) ? cmp_res : exec_base;
  wire [WCT_LANES-1:0] next_exec = buf_lds_oor_i ? (exec_cmp & ~buf_lds_lanes_i) : exec_cmp;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exec_mask_o <= '1;
    end else begin
      exec_mask_o <= next_exec;
    end
  end

  // Alias-name writes are tracked; a raw register-number write is invisible here.
  logic alias_pend;
  wire alias_set = scalar_wr_i & scalar_alias_i;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      alias_pend <= 1'b0;
      branch_stall_o <= 1'b0;
    end else begin
      alias_pend <= alias_set;
      branch_stall_o <= alias_set;
    end
  end

  // Privileged trap scratch, base and memory registers.
  wire tpriv_ok = tpriv_wr_i & priv_i;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_base_o <= '0;
      trap_mem_o <= '0;
    end else if (tpriv_ok) begin
      if (tpriv_sel_i == 2'h0) begin
        trap_base_o <= tpriv_wdata_i;
      end
      if (tpriv_sel_i == 2'h1) begin
        trap_mem_o <= tpriv_wdata_i;
      end
    end
  end

  // Exception status flags, one sticky cell per bit.
  wire [WCT_MV_N-1:0] mv_ok = fetch_or_scalar_i ? '0 : mem_viol_i;
  wire mv_any = |mv_ok;
  wire [WCT_EXC_N-1:0] exc_set = {mv_any, exc_event_i};
  wire [WCT_EXC_N-1:0] exc_flags;
  genvar gi;
  generate
    for (gi = 0; gi < WCT_EXC_N; gi++) begin : g_exc
      wct_sticky u_flag (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .set_i(exc_set[gi]),
        .clr_i(1'b0),
        .wr_i(sts_wr_i),
        .wval_i(sts_wdata_i[WCT_ST_EXC_LO + gi]),
        .q_o(exc_flags[gi])
      );
    end
  endgenerate

  // Trap decision; exceptions need both enable and a present handler.
  wire [WCT_EXC_N-1:0] exc_hit = exc_set & exc_enable_i;
  wire exc_trap = trap_present_i & (|exc_hit);
  wire user_trap = trap_present_i & user_trap_i;
  wire host_trap = trap_present_i & host_trap_i;

  // Context-save request and its deadline counter.
  logic save_req;
  logic [1:0] save_cnt;
  logic save_busy;
  wire save_set = host_save_i | (sts_wr_i & sts_wdata_i[WCT_ST_SAVE]);
  wire next_save = save_set | (sts_wr_i ? sts_wdata_i[WCT_ST_SAVE] : save_req);
  wire save_due = trap_present_i & save_req & ~save_busy &
    ((save_cnt == WCT_SAVE_SLACK_W) | instr_issue_i);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      save_req <= 1'b0;
      save_cnt <= 2'h0;
      save_busy <= 1'b0;
    end else begin
      save_req <= next_save;
      if (!save_req) begin
        save_cnt <= 2'h0;
        save_busy <= 1'b0;
      end else if (save_due) begin
        save_busy <= 1'b1;
      end else if (instr_issue_i && save_cnt != WCT_SAVE_SLACK_W) begin
        save_cnt <= save_cnt + 2'h1;
      end
    end
  end

  wire host_any = host_trap | save_due;
  wct_cause_t cause;
  assign cause = exc_trap ? WCT_TRAP_EXC : host_any ? WCT_TRAP_HOST :
    user_trap ? WCT_TRAP_USER : WCT_TRAP_NONE;
  wire take = (cause != WCT_TRAP_NONE);

  // Captured fields; a memory violation with no other enabled exception carries no rewind so the next counter stays.
  logic [7:0] cap_code;
  logic cap_host;
  always_comb begin
    cap_code = WCT_CODE_EXC;
    cap_host = 1'b0;
    unique case (cause)
      WCT_TRAP_EXC: begin
        cap_code = WCT_CODE_EXC;
      end
      WCT_TRAP_HOST: begin
        cap_host = 1'b1;
        cap_code = host_trap ? host_code_i : WCT_CODE_EXC;
      end
      WCT_TRAP_USER: begin
        cap_code = user_code_i;
      end
      WCT_TRAP_NONE: begin
        cap_code = WCT_CODE_EXC;
      end
    endcase
  end
  wire only_mv = exc_hit[WCT_EX_MEMVIOL] & ~(|exc_hit[WCT_EX_WATCH:0]);
  wire [WCT_REWIND_W-1:0] cap_rewind = (cause == WCT_TRAP_EXC && only_mv) ?
    WCT_REWIND_ZERO : rewind_i;
  wire [63:0] next_info = {WCT_TI_PAD, cap_rewind, cap_host, cap_code, next_pc_i};
  wire [WCT_PC_W-1:0] rew_bytes = WCT_PC_W'(cap_rewind) * WCT_PC_W'(WCT_INSTR_BYTES);

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_info_o <= '0;
      fault_pc_o <= '0;
      trap_take_o <= 1'b0;
    end else begin
      trap_take_o <= take;
      if (take) begin
        trap_info_o <= next_info;
        fault_pc_o <= next_pc_i - rew_bytes;
      end else if (tpriv_ok && tpriv_sel_i == 2'h2) begin
        trap_info_o <= tpriv_wdata_i;
      end
    end
  end

  // First enabled exception cycle (invalid through integer divide), held until software rewrites the status.
  logic [WCT_CYC_W-1:0] exc_cyc;
  logic cyc_held;
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      exc_cyc <= '0;
      cyc_held <= 1'b0;
    end else if (|exc_hit[WCT_EX_INTDIV:0] && !cyc_held) begin
      exc_cyc <= exc_cycle_i;
      cyc_held <= 1'b1;
    end else if (sts_wr_i) begin
      exc_cyc <= sts_wdata_i[WCT_ST_CYC_HI:WCT_ST_CYC_LO];
      cyc_held <= 1'b0;
    end
  end

  // Status word assembly, registered so the output comes from a flip-flop.
  logic [31:0] sts_word;
  always_comb begin
    sts_word = WCT_ST_RESET;
    sts_word[WCT_ST_EXC_LO +: WCT_EXC_N] = exc_flags;
    sts_word[WCT_ST_SAVE] = save_req;
    sts_word[WCT_ST_CYC_HI:WCT_ST_CYC_LO] = exc_cyc;
  end
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_status_o <= WCT_ST_RESET;
    end else begin
      trap_status_o <= sts_word;
    end
  end

  // Guards on the behaviour above.
  a_mask_cmp_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cmp_to_mask |=> cond_mask_o == $past(cmp_res)) else $error("mask not compare result");
  a_exec_copy: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmp_valid_i && cmp_to_exec_i && !buf_lds_oor_i) |=> exec_mask_o == $past(cmp_res))
    else $error("exec not copied");
  a_zero_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    cond_zero_o == (cond_mask_o == '0)) else $error("summary flag wrong");
  a_carry_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (carry_valid_i && !cmp_to_mask) |=> cond_mask_o == $past(carry_out_i))
    else $error("carry not in mask");
  a_wide_dest: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (cmp_valid_i && cmp_wide_i && !carry_valid_i && !scalar_wr_i) |=> $stable(cond_mask_o))
    else $error("wide compare hit mask");
  // A single alias write gives exactly one wait state; a second write may extend it.
  a_alias_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    alias_set |=> branch_stall_o ##1 (!branch_stall_o || alias_pend))
    else $error("alias wait missing");
  a_priv_block: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (tpriv_wr_i && !priv_i) |=> $stable(trap_base_o) && $stable(trap_mem_o))
    else $error("unprivileged write taken");
  a_info_fields: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take |=> trap_info_o[63:61] == WCT_TI_PAD && trap_info_o[47:0] == $past(next_pc_i))
    else $error("trap info layout");
  a_host_flag: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (host_trap_i && trap_present_i && !exc_trap) |=> trap_info_o[56])
    else $error("host flag not set");
  a_exc_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    exc_trap |=> trap_info_o[55:48] == WCT_CODE_EXC && !trap_info_o[56])
    else $error("exception code not zero");
  a_fault_pc: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take |=> fault_pc_o == trap_info_o[47:0] - {trap_info_o[60:57], 2'b00})
    else $error("fault address wrong");
  a_no_handler: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !trap_present_i |=> !trap_take_o) else $error("trap without handler");
  a_sticky_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exc_flags[WCT_EX_MEMVIOL] && !sts_wr_i) |=> exc_flags[WCT_EX_MEMVIOL])
    else $error("violation flag dropped");
  // The event must land even when software rewrites the status in the same cycle.
  a_mv_set: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    ((|mem_viol_i) && !fetch_or_scalar_i) |=> exc_flags[WCT_EX_MEMVIOL])
    else $error("violation not recorded");
  a_mv_rewind: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (exc_trap && only_mv) |=> trap_info_o[60:57] == WCT_REWIND_ZERO)
    else $error("violation trap rewound");
  a_save_bound: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    (save_req && trap_present_i && !save_busy && instr_issue_i) |-> take)
    else $error("save trap late");
endmodule : wct_core

// [verif/wct_seq_model.sv]
// Sequencer stand-in that issues instructions and follows taken traps to the handler base.
// Assumes the block raises trap_take_o for one core clock cycle per trap.
`timescale 1ns/1ps
module wct_seq_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic run_i,
  input wire logic trap_take_i,
  input wire logic [63:0] trap_base_i,
  output logic instr_issue_o,
  output logic [wct_pkg::WCT_PC_W-1:0] next_pc_o
);
  import wct_pkg::*;
  // Outputs move on the falling edge so the block samples settled values.
  // It issues no scalar writes at all, so the raw-number mask hazard never arises.
  always @(negedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_issue_o <= 1'b0;
      next_pc_o <= 48'h0000_0000_1000;
    end else if (trap_take_i) begin
      instr_issue_o <= 1'b0;
      next_pc_o <= trap_base_i[WCT_PC_W-1:0];
    end else begin
      instr_issue_o <= run_i & ~instr_issue_o;
      if (instr_issue_o) next_pc_o <= next_pc_o + 48'(WCT_INSTR_BYTES);
    end
  end
endmodule : wct_seq_model

// [verif/wave_condition_trap_logic_test.sv]
// Self-checking bench for the wave condition and trap logic.
// Assumes wct_seq_model drives issue strobes and the program counter.
`timescale 1ns/1ps
module wave_condition_trap_logic_test;
  import wct_pkg::*;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, run = 1'b0, trap_present_i = 1'b0, priv_i = 1'b0;
  logic cmp_valid_i = 1'b0, cmp_wide_i = 1'b0, cmp_to_exec_i = 1'b0, carry_valid_i = 1'b0;
  logic scalar_wr_i = 1'b0, scalar_alias_i = 1'b0, exec_wr_i = 1'b0, branch_summary_i = 1'b0;
  logic fetch_or_scalar_i = 1'b0, buf_lds_oor_i = 1'b0, user_trap_i = 1'b0, host_trap_i = 1'b0;
  logic host_save_i = 1'b0, sts_wr_i = 1'b0, tpriv_wr_i = 1'b0, got, cond_zero_o, cmp_sgpr_wr_o;
  logic branch_stall_o, trap_take_o, instr_issue_i;
  logic [1:0] tpriv_sel_i = 2'h0;
  logic [3:0] rewind_i = 4'h0;
  logic [5:0] exc_cycle_i = 6'h00, cyc_m = 6'h00;
  logic [7:0] exc_event_i = 8'h00, mem_viol_i = 8'h00, user_code_i = 8'h00, host_code_i = 8'h00;
  logic [8:0] exc_enable_i = 9'h000, sts_m;
  logic [31:0] sts_wdata_i = 32'h0000_0000, seed = 32'hd1e8_ebf2, trap_status_o;
  logic [47:0] fault_pc_o, next_pc_i;
  logic [63:0] cmp_pass_i = 64'h0, carry_out_i = 64'h0, scalar_data_i = 64'h0, exec_data_i = 64'h0;
  logic [63:0] buf_lds_lanes_i = 64'h0, tpriv_wdata_i = 64'h0, ex_m, cm, v, em;
  logic [63:0] cond_mask_o, exec_mask_o, cmp_sgpr_data_o, trap_info_o, trap_base_o, trap_mem_o;
  logic [63:0] tp_m[3] = '{64'h0, 64'h0, 64'h0};
  logic [63:0] exp_q[$], care_q[$];
  int fail_count = 0, cmp_count = 0, n_is;

  // Half-period toggle gives the 5 ns core clock.
  always #2.5 mclk_i = ~mclk_i;

  wct_seq_model i_seq (.mclk_i, .rst_n_i, .run_i(run), .trap_take_i(trap_take_o),
    .trap_base_i(trap_base_o), .instr_issue_o(instr_issue_i), .next_pc_o(next_pc_i));
  wct_core i_dut (.mclk_i, .rst_n_i, .trap_present_i, .priv_i, .exc_enable_i, .cmp_valid_i,
    .cmp_wide_i, .cmp_to_exec_i, .cmp_pass_i, .carry_valid_i, .carry_out_i, .scalar_wr_i,
    .scalar_alias_i, .scalar_data_i, .exec_wr_i, .exec_data_i, .branch_summary_i, .instr_issue_i,
    .next_pc_i, .rewind_i, .exc_event_i, .exc_cycle_i, .mem_viol_i, .fetch_or_scalar_i,
    .buf_lds_oor_i, .buf_lds_lanes_i, .user_trap_i, .user_code_i, .host_trap_i, .host_code_i,
    .host_save_i, .sts_wr_i, .sts_wdata_i, .tpriv_wr_i, .tpriv_sel_i, .tpriv_wdata_i,
    .cond_mask_o, .exec_mask_o, .cond_zero_o, .cmp_sgpr_wr_o, .cmp_sgpr_data_o, .branch_stall_o,
    .trap_status_o, .trap_info_o, .trap_base_o, .trap_mem_o, .trap_take_o, .fault_pc_o);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  task automatic rnd64(output logic [63:0] r);
    seed = lfsr(seed);
    r[31:0] = seed;
    seed = lfsr(seed);
    r[63:32] = seed;
  endtask : rnd64

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got_v);
    cmp_count++;
    if (got_v !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got_v);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic note_trap(input logic [63:0] e, input logic [63:0] c);
    exp_q.push_back(e);
    care_q.push_back(c);
  endtask : note_trap

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // Every trap pulse takes the oldest note; a pulse with nothing noted is a stray trap.
  always @(posedge mclk_i) begin
    #1;
    if (trap_take_o === 1'b1) begin
      if (exp_q.size() == 0) chk("stray trap", 64'h0, 64'h1);
      else begin
        em = care_q.pop_front();
        v = exp_q.pop_front();
        chk("trap_info", v & em, trap_info_o & em);
        if (em[0]) chk("fault_pc", {16'h0000, v[47:0] - {v[60:57], 2'b00}}, 64'(fault_pc_o));
      end
    end
  end

  // Hang guard, sized well past the fewer than two hundred cycles the sequence needs.
  initial begin
    #40_000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    tick(8);
    rst_n_i = 1'b1;
    chk("cond_mask", 64'h0, cond_mask_o);
    chk("exec_mask", {64{1'b1}}, exec_mask_o);
    chk("cond_zero", 64'h1, 64'(cond_zero_o));
    chk("status", 64'h0, 64'(trap_status_o));
    rnd64(exec_data_i);
    exec_wr_i = 1'b1;
    tick(1);
    exec_wr_i = 1'b0;
    ex_m = exec_data_i;
    // Back-to-back narrow compares; the last one passes nothing so the mask must go all zero.
    cmp_valid_i = 1'b1;
    for (int i = 0; i < 6; i++) begin
      rnd64(cmp_pass_i);
      if (i == 5) cmp_pass_i = 64'h0;
      cmp_to_exec_i = (i == 3);
      tick(1);
      cm = ex_m & cmp_pass_i;
      if (i == 3) ex_m = cm;
      chk("cond_mask", cm, cond_mask_o);
      chk("cond_zero", 64'(cm == 64'h0), 64'(cond_zero_o));
      chk("exec_mask", ex_m, exec_mask_o);
    end
    // A wide compare goes to the scalar pair and leaves the mask alone.
    cmp_to_exec_i = 1'b0;
    cmp_wide_i = 1'b1;
    rnd64(cmp_pass_i);
    tick(1);
    cmp_valid_i = 1'b0;
    cmp_wide_i = 1'b0;
    chk("sgpr_wr", 64'h1, 64'(cmp_sgpr_wr_o));
    chk("sgpr_data", ex_m & cmp_pass_i, cmp_sgpr_data_o);
    chk("cond_mask", cm, cond_mask_o);
    rnd64(carry_out_i);
    carry_valid_i = 1'b1;
    tick(1);
    carry_valid_i = 1'b0;
    chk("sgpr_wr", 64'h0, 64'(cmp_sgpr_wr_o));
    chk("cond_mask", carry_out_i, cond_mask_o);
    // Scalar writes by register number, then by alias; only the alias gets a wait state.
    for (int a = 0; a < 2; a++) begin
      scalar_alias_i = a[0];
      rnd64(scalar_data_i);
      if (a == 1) scalar_data_i = 64'h0;
      scalar_wr_i = 1'b1;
      // A raw register-number write is never followed directly by a summary branch.
      branch_summary_i = a[0];
      tick(1);
      scalar_wr_i = 1'b0;
      got = branch_stall_o;
      chk("cond_mask", scalar_data_i, cond_mask_o);
      chk("cond_zero", 64'(a), 64'(cond_zero_o));
      tick(1);
      branch_summary_i = 1'b0;
      chk("stall", 64'(a), 64'(got | branch_stall_o));
    end
    rnd64(buf_lds_lanes_i);
    buf_lds_oor_i = 1'b1;
    tick(1);
    buf_lds_oor_i = 1'b0;
    tick(1);
    ex_m = ex_m & ~buf_lds_lanes_i;
    chk("exec_mask", ex_m, exec_mask_o);
    $display("test masks done");
    // Privileged trap registers, first without privilege, then with it.
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 3; s++) begin
        priv_i = p[0];
        tpriv_sel_i = 2'(s);
        rnd64(tpriv_wdata_i);
        tpriv_wr_i = 1'b1;
        tick(1);
        tpriv_wr_i = 1'b0;
        tick(1);
        if (p == 1) tp_m[s] = tpriv_wdata_i;
        v = (s == 0) ? trap_base_o : (s == 1) ? trap_mem_o : trap_info_o;
        chk("trap_reg", tp_m[s], v);
      end
    end
    priv_i = 1'b0;
    $display("test privilege done");
    // User and host traps, with no handler present and then with one.
    for (int t = 0; t < 4; t++) begin
      trap_present_i = t[1];
      rewind_i = seed[3:0];
      user_code_i = seed[11:4];
      host_code_i = seed[19:12];
      seed = lfsr(seed);
      if (t[1]) note_trap({3'h0, rewind_i, t[0], t[0] ? host_code_i : user_code_i, next_pc_i},
        {64{1'b1}});
      user_trap_i = ~t[0];
      host_trap_i = t[0];
      tick(1);
      user_trap_i = 1'b0;
      host_trap_i = 1'b0;
      tick(3);
    end
    $display("test traps done");
    // Every exception except memory violation once under random enables; status collects all of them.
    exc_enable_i = {1'b1, seed[7:0] | 8'h04};
    sts_m = 9'h000;
    got = 1'b0;
    rewind_i = 4'h3;
    for (int b = 0; b < 8; b++) begin
      exc_cycle_i = seed[5:0];
      seed = lfsr(seed);
      if (exc_enable_i[b]) note_trap({3'h0, rewind_i, 1'b0, WCT_CODE_EXC, next_pc_i},
        {64{1'b1}});
      if (exc_enable_i[b] && b < 7 && !got) cyc_m = exc_cycle_i;
      if (exc_enable_i[b] && b < 7) got = 1'b1;
      exc_event_i = 8'h01 << b;
      sts_m[b] = 1'b1;
      tick(1);
      exc_event_i = 8'h00;
      tick(3);
      chk("status", 64'({10'h000, cyc_m, 7'h00, sts_m}), 64'(trap_status_o));
    end
    // Unprivileged clear, then violations: the first from a fetch, which must not count.
    sts_wr_i = 1'b1;
    tick(1);
    sts_wr_i = 1'b0;
    sts_m = 9'h000;
    rewind_i = 4'h5;
    for (int k = 0; k < 9; k++) begin
      exc_enable_i[8] = k[0];
      fetch_or_scalar_i = (k == 0);
      if (k > 0 && k[0]) note_trap({3'h0, WCT_REWIND_ZERO, 1'b0, WCT_CODE_EXC, next_pc_i},
        {64{1'b1}});
      mem_viol_i = 8'h01 << ((k == 0) ? 0 : k - 1);
      tick(1);
      mem_viol_i = 8'h00;
      tick(3);
      if (k > 0) sts_m[8] = 1'b1;
      chk("status", 64'(sts_m), 64'(trap_status_o & 32'h0000_01FF));
    end
    fetch_or_scalar_i = 1'b0;
    $display("test exceptions done");
    // Context save from the host and from the program, with instructions still issuing.
    run = 1'b1;
    for (int s = 0; s < 2; s++) begin
      note_trap(64'h0100_0000_0000_0000, 64'hE1FF_0000_0000_0000);
      host_save_i = (s == 0);
      sts_wr_i = (s == 1);
      sts_wdata_i = 32'h0000_0400;
      tick(1);
      host_save_i = 1'b0;
      sts_wr_i = 1'b0;
      n_is = 0;
      while (trap_take_o !== 1'b1 && n_is < 12) begin
        if (instr_issue_i === 1'b1) n_is++;
        tick(1);
      end
      chk("save within slack", 64'h1, 64'(n_is <= WCT_SAVE_SLACK + 1));
      tick(1);
      sts_wdata_i = 32'h0000_0000;
      sts_wr_i = 1'b1;
      tick(1);
      sts_wr_i = 1'b0;
      tick(6);
      chk("save bit", 64'h0, 64'(trap_status_o[WCT_ST_SAVE]));
    end
    run = 1'b0;
    $display("test save done");
    chk("pending traps", 64'h0, 64'(exp_q.size()));
    tally_and_finish();
  end
endmodule : wave_condition_trap_logic_test
